//--- rtl/ledcur_regs.sv
// LED current code register bank with byte-wide register port
`timescale 1ns/1ps
`default_nettype none
`include "ledcur_defs.svh"

module ledcur_regs
(
  input wire logic clk_in, // 40 MHz clock
  input wire logic arst_n_in, // Async reset, active low
  input wire logic [`LEDCUR_ADDR_W-1:0] addr_in, // Register offset
  input wire logic wr_en_in, // Write strobe, one cycle
  input wire ledcur_pkg::ledcur_byte_t wr_data_in, // Write data
  output logic [7:0] rd_data_out, // Read data, one cycle after address
  output logic [2:0][9:0] code_out, // Per-channel 10-bit current code
  output logic [2:0] chan_on_out, // Channel enabled (code nonzero)
  output logic [2:0][10:0] scale_out // Current numerator over 1024
);
  import ledcur_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic [1:0] rst_sync;
  logic rst_n_q;

  // Two-stage release of the asynchronous reset
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      rst_sync <= 2'h0;
    end
    else
    begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  // Only the second stage feeds the rest of the design
  assign rst_n_q = rst_sync[1];

  // ------------------------------------------------------------
  // State update
  // ------------------------------------------------------------
  ledcur_state_s state;
  ledcur_state_s next_state;

  // Register writes, read mux and current scaling
  always_comb
  begin
    ledcur_code_t code;
    code = `LEDCUR_CODE_OFF;
    next_state = state;
    if (wr_en_in)
    begin
      if (addr_in == `LEDCUR_OFS_LED1_HIGH)
      begin
        next_state.high_bits[0] =
          wr_data_in[`LEDCUR_HIGH_MSB:`LEDCUR_HIGH_LSB];
      end
      else if (addr_in == `LEDCUR_OFS_LED1_LOW)
      begin
        next_state.low_byte[0] = wr_data_in;
      end
      else if (addr_in == `LEDCUR_OFS_LED2_HIGH)
      begin
        next_state.high_bits[1] =
          wr_data_in[`LEDCUR_HIGH_MSB:`LEDCUR_HIGH_LSB];
      end
      else if (addr_in == `LEDCUR_OFS_LED2_LOW)
      begin
        next_state.low_byte[1] = wr_data_in;
      end
      else if (addr_in == `LEDCUR_OFS_LED3_HIGH)
      begin
        next_state.high_bits[2] =
          wr_data_in[`LEDCUR_HIGH_MSB:`LEDCUR_HIGH_LSB];
      end
      else if (addr_in == `LEDCUR_OFS_LED3_LOW)
      begin
        next_state.low_byte[2] = wr_data_in;
      end
    end
    // Read back, reserved bits as zero
    if (addr_in == `LEDCUR_OFS_LED1_HIGH)
    begin
      next_state.rd_data = {6'h00, state.high_bits[0]};
    end
    else if (addr_in == `LEDCUR_OFS_LED1_LOW)
    begin
      next_state.rd_data = state.low_byte[0];
    end
    else if (addr_in == `LEDCUR_OFS_LED2_HIGH)
    begin
      next_state.rd_data = {6'h00, state.high_bits[1]};
    end
    else if (addr_in == `LEDCUR_OFS_LED2_LOW)
    begin
      next_state.rd_data = state.low_byte[1];
    end
    else if (addr_in == `LEDCUR_OFS_LED3_HIGH)
    begin
      next_state.rd_data = {6'h00, state.high_bits[2]};
    end
    else if (addr_in == `LEDCUR_OFS_LED3_LOW)
    begin
      next_state.rd_data = state.low_byte[2];
    end
    else
    begin
      next_state.rd_data = `LEDCUR_UNMAPPED_READ;
    end
    // Channel on flag and current numerator from the stored code
    for (int i = 0; i < `LEDCUR_CHANNELS; i++)
    begin
      code = {state.high_bits[i], state.low_byte[i]};
      next_state.chan_on[i] = (code != `LEDCUR_CODE_OFF);
      next_state.scale[i] = next_state.chan_on[i] ?
        ({1'b0, code} + 11'h001) : 11'h000;
    end
  end

  // State register, all zero at reset
  always_ff @(posedge clk_in or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Read data, on flags and numerators straight from the state register
  assign rd_data_out = state.rd_data;
  assign chan_on_out = state.chan_on;
  assign scale_out = state.scale;
  // Full codes straight from the code registers
  always_comb
  begin
    for (int i = 0; i < `LEDCUR_CHANNELS; i++)
    begin
      code_out[i] = {state.high_bits[i], state.low_byte[i]};
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  // Every check samples on the rising edge, quiet while in reset
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_q);

  // First channel low byte lands one cycle after its write
  a_led1_low_write: assert property (
    wr_en_in && addr_in == `LEDCUR_OFS_LED1_LOW
    |=> code_out[0][7:0] == $past(wr_data_in))
    else $error("channel one low byte not written");

  // First channel upper bits take only bits 1:0 of the write
  a_led1_high_write: assert property (
    wr_en_in && addr_in == `LEDCUR_OFS_LED1_HIGH
    |=> code_out[0][9:8] == $past(wr_data_in[1:0]))
    else $error("channel one upper bits not written");

  // Second channel upper bits take only bits 1:0 of the write
  a_led2_high_write: assert property (
    wr_en_in && addr_in == `LEDCUR_OFS_LED2_HIGH
    |=> code_out[1][9:8] == $past(wr_data_in[1:0]))
    else $error("channel two upper bits not written");

  // Second channel low byte reads back what was written
  a_led2_low_rw: assert property (
    wr_en_in && addr_in == `LEDCUR_OFS_LED2_LOW
    ##1 !wr_en_in && addr_in == `LEDCUR_OFS_LED2_LOW
    |=> rd_data_out == $past(wr_data_in, 2))
    else $error("channel two low byte read back wrong");

  // Reserved upper bits never show up on a read
  a_reserved_zero: assert property (
    addr_in inside {`LEDCUR_OFS_LED1_HIGH, `LEDCUR_OFS_LED2_HIGH,
      `LEDCUR_OFS_LED3_HIGH} |=> rd_data_out[7:2] == 6'h00)
    else $error("reserved bits read nonzero");

  // Codes come out of reset at zero with every channel off
  a_reset_zero: assert property (
    $rose(rst_n_q) |-> code_out == '0 && chan_on_out == 3'h0)
    else $error("codes not zero after reset");

  // Codes hold their value while no write is made
  a_code_hold: assert property (
    !wr_en_in |=> $stable(code_out))
    else $error("code changed without a write");

  // An all-zero code keeps the channel off
  a_zero_off: assert property (
    code_out[2] == 10'h000 |=> !chan_on_out[2] && scale_out[2] == 11'h000)
    else $error("zero code left channel on");

  // A nonzero code drives code plus one over 1024
  a_scale_value: assert property (
    code_out[1] != 10'h000 |=> chan_on_out[1] &&
      scale_out[1] == {1'b0, $past(code_out[1])} + 11'h001)
    else $error("channel current numerator wrong");

  // Back-to-back writes build the third channel's full code
  a_led3_write: assert property (
    wr_en_in && addr_in == `LEDCUR_OFS_LED3_LOW
    ##1 wr_en_in && addr_in == `LEDCUR_OFS_LED3_HIGH
    |=> code_out[2] == {$past(wr_data_in[1:0]), $past(wr_data_in, 2)})
    else $error("channel three code not written");

  // ------------------------------------------------------------
  // Cover points
  // ------------------------------------------------------------
  // Full scale, minimum code, third channel on, unmapped read
  c_full_scale: cover property (scale_out[0] == 11'h400);
  c_min_code: cover property (code_out[0] == `LEDCUR_CODE_MIN
    ##1 chan_on_out[0]);
  c_led3_on: cover property ($rose(chan_on_out[2]));
  c_unmapped_read: cover property (addr_in == 8'h09
    ##1 rd_data_out == `LEDCUR_UNMAPPED_READ);
endmodule // ledcur_regs
`default_nettype wire

//--- shared/ledcur_defs.svh
// Offsets, fields, reset values and codes of the LED current bank
`ifndef LEDCUR_DEFS_SVH
`define LEDCUR_DEFS_SVH
`define LEDCUR_ADDR_W 8
`define LEDCUR_OFS_LED1_HIGH 8'h03
`define LEDCUR_OFS_LED1_LOW 8'h04
`define LEDCUR_OFS_LED2_HIGH 8'h05
`define LEDCUR_OFS_LED2_LOW 8'h06
`define LEDCUR_OFS_LED3_HIGH 8'h07
`define LEDCUR_OFS_LED3_LOW 8'h08
`define LEDCUR_HIGH_MSB 1
`define LEDCUR_HIGH_LSB 0
`define LEDCUR_RESET_VALUE 8'h00
`define LEDCUR_UNMAPPED_READ 8'h00
`define LEDCUR_CODE_OFF 10'h000
`define LEDCUR_CODE_MIN 10'h033
`define LEDCUR_CODE_FULL 10'h3FF
`define LEDCUR_CHANNELS 3
`endif

//--- shared/ledcur_pkg.sv
// Types of the LED current code register bank
`include "ledcur_defs.svh"
package ledcur_pkg;
  typedef logic [7:0] ledcur_byte_t;
  typedef logic [9:0] ledcur_code_t;
  typedef logic [10:0] ledcur_scale_t;
  typedef struct packed {
    logic [`LEDCUR_CHANNELS-1:0][1:0] high_bits;
    logic [`LEDCUR_CHANNELS-1:0][7:0] low_byte;
    ledcur_byte_t rd_data;
    logic [`LEDCUR_CHANNELS-1:0] chan_on;
    logic [`LEDCUR_CHANNELS-1:0][10:0] scale;
  } ledcur_state_s;
endpackage

//--- verification/ledcur_regs_tb.sv
// Self-checking testbench of the LED current code register bank
`timescale 1ns/1ps
`default_nettype none
`include "ledcur_defs.svh"
module ledcur_regs_tb;
  import ledcur_pkg::*;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic [7:0] addr_in = 8'h00;
  logic wr_en_in = 1'b0;
  ledcur_byte_t wr_data_in = 8'h00;
  logic [7:0] rd_data_out;
  logic [2:0][9:0] code_out;
  logic [2:0] chan_on_out;
  logic [2:0][10:0] scale_out;
  int mismatches = 0;
  int n_checks = 0;
  // -----------------------------------------------------------------
  // Clock and design
  // -----------------------------------------------------------------
  // 25 ns period clock
  always #12.5 clk_in = ~clk_in;
  ledcur_regs DUT (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .addr_in(addr_in), .wr_en_in(wr_en_in), .wr_data_in(wr_data_in),
    .rd_data_out(rd_data_out), .code_out(code_out),
    .chan_on_out(chan_on_out), .scale_out(scale_out));
  // -----------------------------------------------------------------
  // Access and compare tasks
  // -----------------------------------------------------------------
  // Compare one value and count it
  task automatic chk(input string what, input logic [10:0] exp,
                     input logic [10:0] got);
    n_checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One-cycle write strobe, driven off the falling edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_in = a;
    wr_data_in = d;
    wr_en_in = 1'b1;
    @(negedge clk_in);
    wr_en_in = 1'b0;
  endtask
  // Two writes on consecutive edges, strobe held high between them
  task automatic wr2(input logic [7:0] a1, input logic [7:0] d1,
                     input logic [7:0] a2, input logic [7:0] d2);
    @(negedge clk_in);
    addr_in = a1;
    wr_data_in = d1;
    wr_en_in = 1'b1;
    @(negedge clk_in);
    addr_in = a2;
    wr_data_in = d2;
    @(negedge clk_in);
    wr_en_in = 1'b0;
  endtask
  // Read: data is registered on the same edge that samples the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_in);
    addr_in = a;
    wr_en_in = 1'b0;
    @(negedge clk_in);
    chk("rd_data_out", {3'h0, exp}, {3'h0, rd_data_out});
  endtask
  // Print counts and verdict, then stop
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // -----------------------------------------------------------------
  // Test sequence
  // -----------------------------------------------------------------
  // Reset, walk every register, boundary codes, unmapped and re-reset
  initial
  begin
    repeat (12) @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    for (int a = 3; a <= 8; a++)
      rd(a[7:0], 8'h00);
    chk("chan_on_out", 11'h000, {8'h00, chan_on_out});
    $display("test reset_values done");
    for (int a = 3; a <= 8; a++)
      wr(a[7:0], 8'hFF);
    for (int a = 3; a <= 8; a += 2)
    begin
      rd(a[7:0], 8'h03);
      rd(a[7:0] + 8'h01, 8'hFF);
    end
    for (int c = 0; c < 3; c++)
    begin
      chk("code_out", {1'b0, `LEDCUR_CODE_FULL},
          {1'b0, code_out[c]});
      chk("scale_out", 11'h400, scale_out[c]);
    end
    $display("test full_scale done");
    wr(8'h04, 8'h33);
    wr(8'h03, 8'h00);
    wr(8'h05, 8'h00);
    wr(8'h06, 8'h00);
    wr(8'h07, 8'hFC);
    repeat (2) @(negedge clk_in);
    chk("code_out", {1'b0, `LEDCUR_CODE_MIN}, {1'b0, code_out[0]});
    chk("scale_out", 11'h034, scale_out[0]);
    chk("scale_out", 11'h000, scale_out[1]);
    chk("code_out", 11'h0FF, {1'b0, code_out[2]});
    chk("scale_out", 11'h100, scale_out[2]);
    chk("chan_on_out", 11'h005, {8'h00, chan_on_out});
    $display("test min_and_off done");
    wr(8'h09, 8'hAA);
    wr(8'h02, 8'h55);
    rd(8'h09, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h04, 8'h33);
    $display("test unmapped done");
    wr2(8'h08, 8'h5A, 8'h07, 8'hFE);
    chk("code_out", 11'h25A, {1'b0, code_out[2]});
    rd(8'h07, 8'h02);
    chk("scale_out", 11'h25B, scale_out[2]);
    $display("test back_to_back done");
    @(negedge clk_in);
    arst_n_in = 1'b0;
    @(negedge clk_in);
    arst_n_in = 1'b1;
    repeat (3) @(negedge clk_in);
    rd(8'h04, 8'h00);
    rd(8'h08, 8'h00);
    chk("scale_out", 11'h000, scale_out[2]);
    $display("test second_reset done");
    test_done();
  end
endmodule // ledcur_regs_tb
`default_nettype wire
